// ===== hdl/lcrd_defines.vh
// constants of the link control request decoder
// assumes inclusion by bare name from the design files
`ifndef LCRD_DEFINES_VH
`define LCRD_DEFINES_VH

// ----------------------------------------------------------------------
// request key codes (octal 00..05, 20, 21)
// ----------------------------------------------------------------------
`define LCRD_KEY_NOP        5'h00
`define LCRD_KEY_ESTABLISH  5'h01
`define LCRD_KEY_DELETE     5'h02
`define LCRD_KEY_STARTUP    5'h03
`define LCRD_KEY_MAINT      5'h04
`define LCRD_KEY_HALT       5'h05
`define LCRD_KEY_MDM_WR     5'h10
`define LCRD_KEY_MDM_RD     5'h11
`define LCRD_KEY_RSV1_LO    5'h06
`define LCRD_KEY_RSV1_HI    5'h0F
`define LCRD_KEY_RSV2_LO    5'h12
`define LCRD_KEY_RSV2_HI    5'h1F

// ----------------------------------------------------------------------
// slots and protocol states
// ----------------------------------------------------------------------
`define LCRD_NUM_SLOTS      12
`define LCRD_SLOT_LOCS      64
`define LCRD_ST_HALT        2'h0
`define LCRD_ST_STARTUP     2'h1
`define LCRD_ST_RUN         2'h2
`define LCRD_ST_MAINT       2'h3

// ----------------------------------------------------------------------
// response codes
// ----------------------------------------------------------------------
`define LCRD_RSP_NONE       2'h0
`define LCRD_RSP_CTRL       2'h1
`define LCRD_RSP_INFO       2'h2
`define LCRD_ERR_POOL_BUSY  8'h5E
`define LCRD_ERR_PROC       8'h01
`define LCRD_EVT_RUN        8'h02
`define LCRD_MDM_RESET      8'h00
`define LCRD_POLL_RESET     2'h0

`endif

// ===== hdl/lcrd_slot_table.v
// status slot table: 12 slots, each with valid bit, protocol state
// and polling state; link side reports start-up completion by address
`timescale 1ns/10ps
`include "lcrd_defines.vh"

module lcrd_slot_table (
   // clock and reset
   input wire clk_sys_i,
   input wire sys_rst_i,
   // lookup
   input wire [7:0] lk_addr_i,
   output wire lk_hit_o,
   output wire [3:0] lk_idx_o,
   output wire [1:0] lk_state_o,
   output wire [3:0] free_idx_o,
   output wire free_ok_o,
   // update
   input wire wr_en_i,
   input wire [3:0] wr_idx_i,
   input wire wr_valid_i,
   input wire [7:0] wr_addr_i,
   input wire [1:0] wr_state_i,
   input wire wr_poll_en_i,
   input wire [1:0] wr_poll_i,
   input wire wr_pool_en_i,
   input wire wr_pool_i,
   // observation
   output wire [11:0] valid_o,
   output wire [11:0] halted_o,
   output wire [11:0] pool_o,
   output wire [23:0] poll_o
);

   reg [11:0] valid_r;
   reg [11:0] pool_r;
   reg [7:0] addr_r [0:11];
   reg [1:0] state_r [0:11];
   reg [1:0] poll_r [0:11];
   reg hit;
   reg [3:0] hidx;
   reg fok;
   reg [3:0] fidx;
   integer i;
   integer j;

   always @* begin
      hit = 1'b0;
      hidx = 4'h0;
      fok = 1'b0;
      fidx = 4'h0;
      for (i = `LCRD_NUM_SLOTS - 1; i >= 0; i = i - 1) begin
         if (valid_r[i] && addr_r[i] == lk_addr_i) begin
            hit = 1'b1;
            hidx = i[3:0];
         end
         if (!valid_r[i]) begin
            fok = 1'b1;
            fidx = i[3:0];
         end
      end
   end

   assign lk_hit_o = hit;
   assign lk_idx_o = hidx;
   assign lk_state_o = state_r[hidx];
   assign free_idx_o = fidx;
   assign free_ok_o = fok;
   assign valid_o = valid_r;
   assign pool_o = pool_r;

   genvar g;
   generate
      for (g = 0; g < `LCRD_NUM_SLOTS; g = g + 1) begin : obs
         assign halted_o[g] = valid_r[g] && state_r[g] == `LCRD_ST_HALT;
         assign poll_o[2*g+1:2*g] = poll_r[g];
      end
   endgenerate

   always @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         valid_r <= 12'h000;
         pool_r <= 12'h000;
         for (j = 0; j < `LCRD_NUM_SLOTS; j = j + 1) begin
            addr_r[j] <= 8'h00;
            state_r[j] <= `LCRD_ST_HALT;
            poll_r[j] <= `LCRD_POLL_RESET;
         end
      end else if (wr_en_i) begin
         valid_r[wr_idx_i] <= wr_valid_i;
         addr_r[wr_idx_i] <= wr_addr_i;
         state_r[wr_idx_i] <= wr_state_i;
         if (wr_poll_en_i) begin
            poll_r[wr_idx_i] <= wr_poll_i;
         end
         if (wr_pool_en_i) begin
            pool_r[wr_idx_i] <= wr_pool_i;
         end
      end
   end

endmodule // lcrd_slot_table

// ===== hdl/lcrd_request_decoder.v
// control command request decoder for a multipoint link controller
// assumes host strobes one command at a time, only while ready
`timescale 1ns/10ps
`include "lcrd_defines.vh"

// Behaviour
// - key 02 discards the addressed status slot
// - at most twelve tributaries established together
// - key 03 initializes slot, starts start-up
// - start-up done reports run control response; here only while idle with no command strobed, else it is dropped
// - key 04 enters maintenance state
// - maintenance traffic only when both ends maintain
// - key 05 halts, returns outstanding buffers
// - control station skips halted tributaries when polling
// - tributary station ignores polls when halted
// - halting keeps slot contents unchanged
// - halt at address zero returns pool
// - pool busy on global halt: error 136
// - key 20 writes parameter byte to modem
// - key 21 returns modem value in info
// - keys 6-17 and 22-37 octal reserved
// - pool and poll bits act with start-up
// - key 00 is a null command
// - key 01 creates slot; others need one
// - twelve slots of 64 byte locations
module lcrd_request_decoder (
   // clock and reset
   input wire clk_sys_i,
   input wire sys_rst_i,
   // command from host
   input wire cmd_valid_i,
   input wire [4:0] request_key_i,
   input wire [7:0] tributary_address_byte_i,
   input wire [7:0] command_param_byte_i,
   input wire [7:0] request_flag_byte_i,
   output wire cmd_ready_o,
   // station role: high at the control station
   input wire control_station_i,
   // link engine
   input wire startup_done_i,
   input wire [7:0] startup_done_addr_i,
   input wire pool_in_use_i,
   input wire [7:0] modem_in_i,
   input wire poll_req_i,
   input wire [7:0] poll_addr_i,
   output reg poll_permit_o,
   output reg poll_answer_o,
   output reg maint_traffic_o,
   output reg buf_return_o,
   output reg [7:0] buf_return_addr_o,
   output reg pool_return_o,
   output reg [7:0] modem_ctrl_o,
   output reg [11:0] slot_valid_o,
   output reg [23:0] poll_state_o,
   output reg [11:0] pool_enable_o,
   // response to host
   output reg rsp_valid_o,
   output reg [1:0] rsp_type_o,
   output reg [7:0] rsp_addr_o,
   output reg [7:0] rsp_code_o,
   output reg [15:0] low_param_word_o
);

   // ----------------------------------------------------------------------
   // flag byte layout (bits 12/13 and pool bits of the upper byte)
   // ----------------------------------------------------------------------
   localparam FLG_POOL_EN = 0;
   localparam FLG_POOL_DIS = 1;
   localparam FLG_UNLATCH = 4;
   localparam FLG_LATCH = 5;

   // ----------------------------------------------------------------------
   // decode state
   // ----------------------------------------------------------------------
   localparam S_IDLE = 2'b00;
   localparam S_EXEC = 2'b01;
   localparam S_DONE = 2'b10;

   reg [1:0] fsm_r;
   reg [1:0] fsm_nxt;
   reg [4:0] key_r;
   reg [7:0] addr_r;
   reg [7:0] param_r;
   reg [7:0] flag_r;
   reg [7:0] mdm_s1_r;
   reg [7:0] mdm_s2_r;

   wire lk_hit;
   wire [3:0] lk_idx;
   wire [1:0] lk_state;
   wire [3:0] free_idx;
   wire free_ok;
   wire [11:0] valid_w;
   wire [11:0] halted_w;
   wire [11:0] pool_w;
   wire [23:0] poll_w;

   reg wr_en;
   reg [3:0] wr_idx;
   reg wr_valid;
   reg [1:0] wr_state;
   reg wr_poll_en;
   reg [1:0] wr_poll;
   reg wr_pool_en;
   reg wr_pool;
   reg [7:0] lk_addr;
   reg err;
   reg [7:0] err_code;
   reg ctrl_ok;

   function is_reserved;
      input [4:0] k;
      begin
         is_reserved = (k >= `LCRD_KEY_RSV1_LO && k <= `LCRD_KEY_RSV1_HI) ||
                       (k >= `LCRD_KEY_RSV2_LO && k <= `LCRD_KEY_RSV2_HI);
      end
   endfunction

   // flag bits apply with keys 00, 01, 03, 04
   function flags_apply;
      input [4:0] k;
      begin
         flags_apply = k == `LCRD_KEY_NOP || k == `LCRD_KEY_ESTABLISH ||
                       k == `LCRD_KEY_STARTUP || k == `LCRD_KEY_MAINT;
      end
   endfunction

   assign cmd_ready_o = (fsm_r == S_IDLE);

   // start-up completions and poll lookups share the table port; exec wins
   always @* begin
      if (fsm_r == S_EXEC) begin
         lk_addr = addr_r;
      end else if (startup_done_i) begin
         lk_addr = startup_done_addr_i;
      end else begin
         lk_addr = poll_addr_i;
      end
   end

   lcrd_slot_table u_slots (
      .clk_sys_i(clk_sys_i),
      .sys_rst_i(sys_rst_i),
      .lk_addr_i(lk_addr),
      .lk_hit_o(lk_hit),
      .lk_idx_o(lk_idx),
      .lk_state_o(lk_state),
      .free_idx_o(free_idx),
      .free_ok_o(free_ok),
      .wr_en_i(wr_en),
      .wr_idx_i(wr_idx),
      .wr_valid_i(wr_valid),
      .wr_addr_i(addr_r),
      .wr_state_i(wr_state),
      .wr_poll_en_i(wr_poll_en),
      .wr_poll_i(wr_poll),
      .wr_pool_en_i(wr_pool_en),
      .wr_pool_i(wr_pool),
      .valid_o(valid_w),
      .halted_o(halted_w),
      .pool_o(pool_w),
      .poll_o(poll_w)
   );

   // ----------------------------------------------------------------------
   // command execution
   // ----------------------------------------------------------------------
   always @* begin
      fsm_nxt = fsm_r;
      wr_en = 1'b0;
      wr_idx = lk_idx;
      wr_valid = 1'b1;
      wr_state = lk_state;
      wr_poll_en = 1'b0;
      wr_poll = `LCRD_POLL_RESET;
      wr_pool_en = 1'b0;
      wr_pool = 1'b0;
      err = 1'b0;
      err_code = `LCRD_ERR_PROC;
      ctrl_ok = 1'b0;
      case (fsm_r)
         S_IDLE: begin
            if (cmd_valid_i) begin
               fsm_nxt = S_EXEC;
            end else if (startup_done_i && lk_hit && lk_state == `LCRD_ST_STARTUP) begin
               wr_en = 1'b1;
               wr_state = `LCRD_ST_RUN;
               ctrl_ok = 1'b1;
            end
         end
         S_EXEC: begin
            fsm_nxt = S_DONE;
            if (is_reserved(key_r)) begin
               err = 1'b1;
            end else begin
               case (key_r)
                  `LCRD_KEY_NOP: begin
                     wr_en = 1'b0;
                  end
                  `LCRD_KEY_ESTABLISH: begin
                     if (lk_hit) begin
                        wr_en = 1'b1;
                     end else if (free_ok && addr_r != 8'h00) begin
                        wr_en = 1'b1;
                        wr_idx = free_idx;
                        wr_state = `LCRD_ST_HALT;
                     end else begin
                        err = 1'b1;
                     end
                  end
                  `LCRD_KEY_DELETE: begin
                     if (lk_hit && lk_state == `LCRD_ST_HALT) begin
                        wr_en = 1'b1;
                        wr_valid = 1'b0;
                        wr_pool_en = 1'b1;
                     end else begin
                        err = 1'b1;
                     end
                  end
                  `LCRD_KEY_STARTUP, `LCRD_KEY_MAINT: begin
                     if (lk_hit && lk_state == `LCRD_ST_HALT) begin
                        wr_en = 1'b1;
                        wr_state = (key_r == `LCRD_KEY_STARTUP) ? `LCRD_ST_STARTUP
                                                                : `LCRD_ST_MAINT;
                     end else begin
                        err = 1'b1;
                     end
                  end
                  `LCRD_KEY_HALT: begin
                     if (addr_r == 8'h00) begin
                        if (pool_in_use_i || pool_w != 12'h000) begin
                           err = 1'b1;
                           err_code = `LCRD_ERR_POOL_BUSY;
                        end
                     end else if (lk_hit) begin
                        wr_en = 1'b1;
                        wr_state = `LCRD_ST_HALT;
                     end else begin
                        err = 1'b1;
                     end
                  end
                  `LCRD_KEY_MDM_WR, `LCRD_KEY_MDM_RD: begin
                     wr_en = 1'b0;
                  end
                  default: begin
                     err = 1'b1;
                  end
               endcase
               // pool and polling bits ride along with the request
               if (!err && flags_apply(key_r) && (lk_hit || wr_en)) begin
                  wr_en = 1'b1;
                  wr_pool_en = flag_r[FLG_POOL_EN] | flag_r[FLG_POOL_DIS];
                  wr_pool = flag_r[FLG_POOL_EN];
                  wr_poll_en = flag_r[FLG_LATCH] | flag_r[FLG_UNLATCH];
                  wr_poll = flag_r[FLG_LATCH] ? param_r[1:0] : `LCRD_POLL_RESET;
               end
            end
         end
         S_DONE: begin
            fsm_nxt = S_IDLE;
         end
         default: begin
            fsm_nxt = S_IDLE;
         end
      endcase
   end

   // ----------------------------------------------------------------------
   // registers and responses
   // ----------------------------------------------------------------------
   always @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         fsm_r <= S_IDLE;
         key_r <= 5'h00;
         addr_r <= 8'h00;
         param_r <= 8'h00;
         flag_r <= 8'h00;
         mdm_s1_r <= 8'h00;
         mdm_s2_r <= 8'h00;
         modem_ctrl_o <= `LCRD_MDM_RESET;
         rsp_valid_o <= 1'b0;
         rsp_type_o <= `LCRD_RSP_NONE;
         rsp_addr_o <= 8'h00;
         rsp_code_o <= 8'h00;
         low_param_word_o <= 16'h0000;
         buf_return_o <= 1'b0;
         buf_return_addr_o <= 8'h00;
         pool_return_o <= 1'b0;
         poll_permit_o <= 1'b0;
         poll_answer_o <= 1'b0;
         maint_traffic_o <= 1'b0;
         slot_valid_o <= 12'h000;
         poll_state_o <= 24'h00_0000;
         pool_enable_o <= 12'h000;
      end else begin
         fsm_r <= fsm_nxt;
         mdm_s1_r <= modem_in_i;
         mdm_s2_r <= mdm_s1_r;
         slot_valid_o <= valid_w;
         poll_state_o <= poll_w;
         pool_enable_o <= pool_w;
         rsp_valid_o <= 1'b0;
         buf_return_o <= 1'b0;
         pool_return_o <= 1'b0;
         if (fsm_r == S_IDLE && cmd_valid_i) begin
            key_r <= request_key_i;
            addr_r <= tributary_address_byte_i;
            param_r <= command_param_byte_i;
            flag_r <= request_flag_byte_i;
         end
         // polls: only non-exec cycles see the poll address on the table
         if (fsm_r != S_EXEC && !startup_done_i) begin
            poll_permit_o <= poll_req_i && control_station_i && lk_hit &&
                             lk_state != `LCRD_ST_HALT;
            poll_answer_o <= poll_req_i && !control_station_i && lk_hit &&
                             lk_state != `LCRD_ST_HALT;
            maint_traffic_o <= lk_hit && lk_state == `LCRD_ST_MAINT;
         end else begin
            poll_permit_o <= 1'b0;
            poll_answer_o <= 1'b0;
         end
         if (ctrl_ok) begin
            rsp_valid_o <= 1'b1;
            rsp_type_o <= `LCRD_RSP_CTRL;
            rsp_addr_o <= startup_done_addr_i;
            rsp_code_o <= `LCRD_EVT_RUN;
         end
         if (fsm_r == S_EXEC) begin
            if (err) begin
               rsp_valid_o <= 1'b1;
               rsp_type_o <= `LCRD_RSP_CTRL;
               rsp_addr_o <= addr_r;
               rsp_code_o <= err_code;
            end else if (key_r == `LCRD_KEY_MDM_WR) begin
               modem_ctrl_o <= param_r;
            end else if (key_r == `LCRD_KEY_MDM_RD) begin
               rsp_valid_o <= 1'b1;
               rsp_type_o <= `LCRD_RSP_INFO;
               rsp_addr_o <= addr_r;
               rsp_code_o <= 8'h00;
               low_param_word_o <= {8'h00, mdm_s2_r};
            end else if (key_r == `LCRD_KEY_HALT) begin
               buf_return_o <= (addr_r != 8'h00);
               buf_return_addr_o <= addr_r;
               pool_return_o <= (addr_r == 8'h00);
            end
         end
      end
   end

endmodule // lcrd_request_decoder

// ===== verification/lcrd_dec_properties.sv
// port timing checker of the control request decoder
// assumes bind onto lcrd_request_decoder, one clock domain
`timescale 1ns/10ps
module lcrd_dec_properties (
   // clock and reset
   input wire clk_sys_i,
   input wire sys_rst_i,
   // command and link inputs
   input wire cmd_valid_i,
   input wire [4:0] request_key_i,
   input wire [7:0] tributary_address_byte_i,
   input wire [7:0] command_param_byte_i,
   input wire startup_done_i,
   input wire pool_in_use_i,
   // observed outputs
   input wire cmd_ready_o,
   input wire [11:0] pool_enable_o,
   input wire pool_return_o,
   input wire [7:0] modem_ctrl_o,
   input wire rsp_valid_o,
   input wire [1:0] rsp_type_o,
   input wire [7:0] rsp_code_o
);
   wire take = cmd_valid_i && cmd_ready_o;
   wire rsv = (request_key_i >= 5'h06 && request_key_i <= 5'h0F) || request_key_i >= 5'h12;
   wire ghalt = take && request_key_i == 5'h05 && tributary_address_byte_i == 8'h00;
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (sys_rst_i);
   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   ready_gap_a: assert property (
      take |=> !cmd_ready_o [*2] ##1 cmd_ready_o) else $error("ready gap after command wrong");
   reserved_key_a: assert property (
      take && rsv |-> ##2 rsp_valid_o && rsp_code_o == 8'h01) else $error("reserved key not refused");
   null_quiet_a: assert property (
      take && request_key_i == 5'h00 |-> ##2 !rsp_valid_o) else $error("null command answered");
   modem_write_a: assert property (
      take && request_key_i == 5'h10 |-> ##2 modem_ctrl_o == $past(command_param_byte_i, 2))
      else $error("modem register not written");
   modem_read_a: assert property (
      take && request_key_i == 5'h11 |-> ##2 rsp_valid_o && rsp_type_o == 2'h2) else $error("no info response");
   pool_busy_a: assert property (
      ghalt && pool_in_use_i |-> ##2 rsp_valid_o && rsp_code_o == 8'h5E) else $error("pool busy not reported");
   pool_return_a: assert property (
      ghalt && !pool_in_use_i && pool_enable_o == 12'h000 |-> ##2 pool_return_o && !rsp_valid_o)
      else $error("common pool not returned");
   run_report_a: assert property (
      startup_done_i && cmd_ready_o && !cmd_valid_i |=> rsp_valid_o && rsp_type_o == 2'h1 && rsp_code_o == 8'h02)
      else $error("run state not reported");
   rsp_cause_a: assert property (
      rsp_valid_o |-> $past(take, 2) || $past(startup_done_i && cmd_ready_o)) else $error("response without cause");
endmodule // lcrd_dec_properties

bind lcrd_request_decoder lcrd_dec_properties u_props (
   .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .cmd_valid_i(cmd_valid_i), .request_key_i(request_key_i),
   .tributary_address_byte_i(tributary_address_byte_i), .command_param_byte_i(command_param_byte_i),
   .startup_done_i(startup_done_i), .pool_in_use_i(pool_in_use_i), .cmd_ready_o(cmd_ready_o),
   .pool_enable_o(pool_enable_o), .pool_return_o(pool_return_o), .modem_ctrl_o(modem_ctrl_o),
   .rsp_valid_o(rsp_valid_o), .rsp_type_o(rsp_type_o), .rsp_code_o(rsp_code_o));

// ===== verification/lcrd_host_model.sv
// host program model: presents one control command at a time
// assumes the decoder takes a command at a rising edge with ready high
`timescale 1ns/10ps
module lcrd_host_model (
   // clock
   input wire clk_sys_i,
   // command handshake
   input wire cmd_ready_i,
   output reg cmd_valid_o,
   output reg [4:0] key_o,
   output reg [7:0] addr_o,
   output reg [7:0] param_o,
   output reg [7:0] flags_o
);
   initial begin
      cmd_valid_o = 1'b0;
      key_o = 5'h00;
      addr_o = 8'h00;
      param_o = 8'h00;
      flags_o = 8'h00;
   end
   // callers halt before delete, start-up and maintenance unless a refusal is wanted
   // reserved keys go out only when a refusal is wanted
   task send(input [4:0] k, input [7:0] a, input [7:0] p, input [7:0] f);
      begin
         @(negedge clk_sys_i);
         while (cmd_ready_i !== 1'b1) @(negedge clk_sys_i);
         cmd_valid_o = 1'b1;
         key_o = k;
         addr_o = a;
         param_o = p;
         flags_o = f;
         @(posedge clk_sys_i);
         @(negedge clk_sys_i);
         // released fields must not keep the old command visible
         cmd_valid_o = 1'b0;
         key_o = ~key_o;
         addr_o = ~addr_o;
         param_o = ~param_o;
         flags_o = ~flags_o;
         // return while the answer pulse of the exec cycle still stands
         @(posedge clk_sys_i);
         @(negedge clk_sys_i);
      end
   endtask
endmodule // lcrd_host_model

// ===== verification/link_control_request_decoder_bench.sv
// self-checking bench of the control request decoder
// assumes host model drives commands, bench drives link side
`timescale 1ns/10ps
module link_control_request_decoder_bench;
   reg clk_sys_i = 1'b0;
   reg sys_rst_i = 1'b1;
   reg ctl_st = 1'b1;
   reg sdone = 1'b0;
   reg [7:0] sdone_addr = 8'h00;
   reg pool_busy = 1'b0;
   reg [7:0] mdm_in = 8'h00;
   reg poll_req = 1'b0;
   reg [7:0] poll_addr = 8'h00;
   reg [31:0] seed = 32'h4b2c;
   reg got_buf, got_pool;
   reg [7:0] got_baddr;
   integer error_cnt = 0;
   integer n_tests = 0;
   integer i;
   wire c_valid, c_ready, permit, answer, maint, buf_ret, pool_ret, rsp_valid;
   wire [4:0] c_key;
   wire [7:0] c_addr, c_param, c_flags, buf_addr, mdm_ctrl, rsp_addr, rsp_code;
   wire [11:0] slot_valid, pool_en;
   wire [23:0] poll_state;
   wire [1:0] rsp_type;
   wire [15:0] low_param;
   lcrd_host_model host (.clk_sys_i(clk_sys_i), .cmd_ready_i(c_ready), .cmd_valid_o(c_valid), .key_o(c_key),
      .addr_o(c_addr), .param_o(c_param), .flags_o(c_flags));
   lcrd_request_decoder DUT (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .cmd_valid_i(c_valid),
      .request_key_i(c_key), .tributary_address_byte_i(c_addr), .command_param_byte_i(c_param),
      .request_flag_byte_i(c_flags), .cmd_ready_o(c_ready), .control_station_i(ctl_st), .startup_done_i(sdone),
      .startup_done_addr_i(sdone_addr), .pool_in_use_i(pool_busy), .modem_in_i(mdm_in), .poll_req_i(poll_req),
      .poll_addr_i(poll_addr), .poll_permit_o(permit), .poll_answer_o(answer), .maint_traffic_o(maint),
      .buf_return_o(buf_ret), .buf_return_addr_o(buf_addr), .pool_return_o(pool_ret), .modem_ctrl_o(mdm_ctrl),
      .slot_valid_o(slot_valid), .poll_state_o(poll_state), .pool_enable_o(pool_en), .rsp_valid_o(rsp_valid),
      .rsp_type_o(rsp_type), .rsp_addr_o(rsp_addr), .rsp_code_o(rsp_code), .low_param_word_o(low_param));
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   initial begin
      forever #5 clk_sys_i = ~clk_sys_i;
   end
   function [31:0] xs(input [31:0] s);
      reg [31:0] t;
      begin
         t = s ^ (s << 13);
         t = t ^ (t >> 17);
         xs = t ^ (t << 5);
      end
   endfunction
   function is_rsv(input [4:0] k);
      is_rsv = (k >= 5'h06 && k <= 5'h0F) || k >= 5'h12;
   endfunction
   task check(input [8*10:1] name, input [31:0] seen, input [31:0] exp);
      begin
         n_tests = n_tests + 1;
         if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("Error %0s expected %h seen %h", name, exp, seen);
         end
      end
   endtask
   // response pulses stand one cycle, so sample in that cycle
   task cmd(input [4:0] k, input [7:0] a, input [7:0] p, input [7:0] f, input ev, input [7:0] ec);
      begin
         host.send(k, a, p, f);
         got_buf = buf_ret;
         got_baddr = buf_addr;
         got_pool = pool_ret;
         check("rsp_valid", {31'h0, rsp_valid}, {31'h0, ev});
         if (ev && k != 5'h11) check("rsp_code", {24'h0, rsp_code}, {24'h0, ec});
         if (ev) check("rsp_addr", {24'h0, rsp_addr}, {24'h0, a});
         if (ev) check("rsp_type", {30'h0, rsp_type}, (k == 5'h11) ? 32'h0000_0002 : 32'h0000_0001);
      end
   endtask
   task poll(input [7:0] a);
      begin
         @(negedge clk_sys_i);
         poll_addr = a;
         poll_req = 1'b1;
         @(negedge clk_sys_i);
         poll_req = 1'b0;
      end
   endtask
   task done(input [7:0] a);
      begin
         @(negedge clk_sys_i);
         sdone = 1'b1;
         sdone_addr = a;
         @(negedge clk_sys_i);
         sdone = 1'b0;
         check("run_code", {24'h0, rsp_code}, 32'h0000_0002);
         check("run_addr", {24'h0, rsp_addr}, {24'h0, a});
      end
   endtask
   task final_report;
      begin
         $display("checks %0d mismatches %0d", n_tests, error_cnt);
         if (error_cnt == 0 && n_tests > 0) $display("SIMULATION PASSED");
         else $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   initial begin
      #300000;
      error_cnt = error_cnt + 1;
      final_report;
   end
   initial begin
      repeat (6) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      sys_rst_i = 1'b0;
      check("ready", {31'h0, c_ready}, 32'h0000_0001);
      check("modem_rst", {24'h0, mdm_ctrl}, 32'h0000_0000);
      for (i = 1; i <= 12; i = i + 1) cmd(5'h01, i[7:0], 8'h00, 8'h00, 1'b0, 8'h00);
      cmd(5'h01, 8'h0D, 8'h00, 8'h00, 1'b1, 8'h01);
      check("slots", {20'h0, slot_valid}, 32'h0000_0FFF);
      for (i = 0; i < 32; i = i + 1) if (is_rsv(i[4:0])) cmd(i[4:0], 8'h01, 8'h00, 8'h00, 1'b1, 8'h01);
      cmd(5'h00, 8'h01, 8'h00, 8'h00, 1'b0, 8'h00);
      cmd(5'h03, 8'h03, 8'h00, 8'h00, 1'b0, 8'h00);
      cmd(5'h03, 8'h03, 8'h00, 8'h00, 1'b1, 8'h01);
      done(8'h03);
      cmd(5'h04, 8'h03, 8'h00, 8'h00, 1'b1, 8'h01);
      cmd(5'h05, 8'h03, 8'h00, 8'h00, 1'b0, 8'h00);
      check("buf_ret", {23'h0, got_buf, got_baddr}, 32'h0000_0103);
      cmd(5'h04, 8'h03, 8'h00, 8'h00, 1'b0, 8'h00);
      poll(8'h03);
      check("maint", {31'h0, maint}, 32'h0000_0001);
      cmd(5'h05, 8'h03, 8'h00, 8'h00, 1'b0, 8'h00);
      cmd(5'h03, 8'h03, 8'h00, 8'h00, 1'b0, 8'h00);
      cmd(5'h03, 8'h05, 8'h00, 8'h00, 1'b0, 8'h00);
      done(8'h05);
      poll(8'h04);
      check("permit_h", {31'h0, permit}, 32'h0000_0000);
      poll(8'h05);
      check("permit_r", {31'h0, permit}, 32'h0000_0001);
      ctl_st = 1'b0;
      poll(8'h04);
      check("answer_h", {31'h0, answer}, 32'h0000_0000);
      poll(8'h05);
      check("answer_r", {31'h0, answer}, 32'h0000_0001);
      ctl_st = 1'b1;
      cmd(5'h02, 8'h05, 8'h00, 8'h00, 1'b1, 8'h01);
      cmd(5'h05, 8'h05, 8'h00, 8'h00, 1'b0, 8'h00);
      cmd(5'h02, 8'h05, 8'h00, 8'h00, 1'b0, 8'h00);
      // slot copies trail the table by one cycle
      @(negedge clk_sys_i);
      check("slot_cnt", $countones(slot_valid), 32'h0000_000B);
      cmd(5'h03, 8'h05, 8'h00, 8'h00, 1'b1, 8'h01);
      pool_busy = 1'b1;
      cmd(5'h05, 8'h00, 8'h00, 8'h00, 1'b1, 8'h5E);
      pool_busy = 1'b0;
      cmd(5'h05, 8'h00, 8'h00, 8'h00, 1'b0, 8'h00);
      check("pool_ret", {31'h0, got_pool}, 32'h0000_0001);
      cmd(5'h03, 8'h04, 8'h02, 8'h21, 1'b0, 8'h00);
      @(negedge clk_sys_i);
      check("pool_en", $countones(pool_en), 32'h0000_0001);
      check("poll_st", $countones(poll_state), 32'h0000_0001);
      cmd(5'h05, 8'h00, 8'h00, 8'h00, 1'b1, 8'h5E);
      for (i = 0; i < 4; i = i + 1) begin
         seed = xs(seed);
         cmd(5'h10, 8'h01, seed[7:0], 8'h00, 1'b0, 8'h00);
         check("modem_wr", {24'h0, mdm_ctrl}, {24'h0, seed[7:0]});
         mdm_in = seed[15:8];
         repeat (3) @(negedge clk_sys_i);
         cmd(5'h11, 8'h01, 8'h00, 8'h00, 1'b1, 8'h00);
         check("modem_rd", {16'h0, rsp_type, 6'h0, low_param[7:0]}, {16'h0, 2'h2, 6'h0, seed[15:8]});
      end
      final_report;
   end
endmodule // link_control_request_decoder_bench
